/* File: rtl/tmr_top.sv */
// Triple timer: register front end, event sources, pins and interrupts
`timescale 1ns/1ps
`include "tmr_defs.svh"
`default_nettype none
module tmr_top #(
  parameter int NCH = `TMR_NUM_CHAN,
  parameter int CW = `TMR_CNT_W,
  parameter int PRESCALE = `TMR_PRESCALE
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [`TMR_ADDR_W-1:0] addr_i,
  input wire logic [`TMR_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`TMR_DATA_W-1:0] rdata_o,
  input wire logic [NCH-1:0] pin_in_i,
  output logic [NCH-1:0] pin_out_o,
  output logic [NCH-1:0] pin_oe_o,
  output logic irq_o
);
  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam int IW = 2 * NCH;

  // ---------------------------------------------------------------------------
  // Per-channel register state
  // ---------------------------------------------------------------------------
  logic [NCH-1:0] te_reg;
  logic [NCH-1:0] overflow_irq_enable_reg;
  logic [NCH-1:0] compare_irq_enable_reg;
  logic [NCH-1:0] inv_reg;
  logic [NCH-1:0] trm_reg;
  logic [NCH-1:0] dir_reg;
  logic [NCH-1:0] gpio_reg;
  logic [NCH-1:0] cmp_flag_reg;
  logic [NCH-1:0] ovf_flag_reg;
  logic [3:0] mode_reg [NCH];
  logic [CW-1:0] load_reg [NCH];
  logic [CW-1:0] cmp_reg [NCH];
  logic [CW-1:0] capt_reg [NCH];
  logic [CW-1:0] count_w [NCH];
  logic [NCH-1:0] hit_w;
  logic [NCH-1:0] ovf_w;
  logic [NCH-1:0] sel_w;
  logic [NCH-1:0] level_reg;
  logic [NCH-1:0] out_reg;
  logic [NCH-1:0] drive_reg;
  logic [NCH-1:0] oe_reg;
  logic [NCH-1:0] pin_sync;
  logic [NCH-1:0] pin_lvl;

  // ---------------------------------------------------------------------------
  // Shared registers
  // ---------------------------------------------------------------------------
  logic [IW-1:0] irq_sts_reg;
  logic [IW-1:0] irq_en_reg;
  logic [IW-1:0] irq_set;
  logic [IW-1:0] irq_clr;
  logic irq_reg;
  logic [PW-1:0] pre_reg;
  logic tick;
  logic any_te;
  logic [3:0] sub;
  logic [`TMR_DATA_W-1:0] rdata_reg;
  logic [`TMR_DATA_W-1:0] rdata_next;

  assign sub = addr_i[3:0];
  assign any_te = |te_reg;

  // ---------------------------------------------------------------------------
  // Internal clock source
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_reg <= '0;
    end else if (ce_i) begin
      if (pre_reg == PW'(PRESCALE - 1)) begin
        pre_reg <= '0;
      end else begin
        pre_reg <= pre_reg + PW'(1);
      end
    end
  end

  assign tick = (pre_reg == PW'(PRESCALE - 1));

  tmr_sync #(
    .W(NCH)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .async_i(pin_in_i),
    .sync_o(pin_sync)
  );

  // Polarity applied after synchronising
  assign pin_lvl = pin_sync ^ inv_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      level_reg <= '0;
    end else if (ce_i) begin
      level_reg <= pin_lvl;
    end
  end

  // ---------------------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    tmr_chan_if #(.CW(CW)) ch_if ();
    logic rise;
    logic fall;
    logic is_out;
    logic wr_csr;
    logic wr_load;
    logic wr_cmp;

    assign sel_w[i] = (addr_i < `TMR_CHAN_SPAN) && (addr_i[5:4] == 2'(i));
    assign wr_csr = wr_i && sel_w[i] && sub == `TMR_CSR_OFS;
    assign wr_load = wr_i && sel_w[i] && sub == `TMR_LOAD_OFS;
    assign wr_cmp = wr_i && sel_w[i] && sub == `TMR_CMP_OFS;
    assign rise = pin_lvl[i] && !level_reg[i];
    assign fall = !pin_lvl[i] && level_reg[i];

    // Output-type modes drive the pin
    always_comb begin
      case (tmr_pkg::tmr_mode_type'(mode_reg[i]))
        tmr_pkg::TMR_MODE_PULSE, tmr_pkg::TMR_MODE_TOGGLE, tmr_pkg::TMR_MODE_PWM,
        tmr_pkg::TMR_MODE_WD_PULSE, tmr_pkg::TMR_MODE_WD_TOGGLE: is_out = 1'b1;
        default: is_out = 1'b0;
      endcase
    end

    assign ch_if.en = te_reg[i];
    assign ch_if.mode = tmr_pkg::tmr_mode_type'(mode_reg[i]);
    assign ch_if.trm = trm_reg[i];
    assign ch_if.load_val = load_reg[i];
    assign ch_if.cmp_val = cmp_reg[i];
    assign ch_if.evt = (mode_reg[i] == tmr_pkg::TMR_MODE_EVENT) ? rise : tick;
    // Watchdog restarts from the load value held before this write
    assign ch_if.load_wr = wr_load && (mode_reg[i] == tmr_pkg::TMR_MODE_WD_PULSE
                                       || mode_reg[i] == tmr_pkg::TMR_MODE_WD_TOGGLE);
    assign count_w[i] = ch_if.count;
    assign hit_w[i] = ch_if.cmp_hit;
    assign ovf_w[i] = ch_if.ovf;

    tmr_chan #(
      .CW(CW)
    ) u_chan (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .bus(ch_if.chan)
    );

    // Control fields
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        te_reg[i] <= 1'b0;
        overflow_irq_enable_reg[i] <= 1'b0;
        compare_irq_enable_reg[i] <= 1'b0;
        mode_reg[i] <= 4'h0;
        inv_reg[i] <= 1'b0;
        trm_reg[i] <= 1'b0;
        dir_reg[i] <= 1'b0;
      end else if (ce_i && wr_csr) begin
        te_reg[i] <= wdata_i[`TMR_TE_BIT];
        overflow_irq_enable_reg[i] <= wdata_i[`TMR_OVERFLOW_IRQ_ENABLE_BIT];
        compare_irq_enable_reg[i] <= wdata_i[`TMR_COMPARE_IRQ_ENABLE_BIT];
        mode_reg[i] <= wdata_i[`TMR_MODE_MSB:`TMR_MODE_LSB];
        inv_reg[i] <= wdata_i[`TMR_INV_BIT];
        trm_reg[i] <= wdata_i[`TMR_TRM_BIT];
        dir_reg[i] <= wdata_i[`TMR_DIR_BIT];
      end
    end

    // GPIO data: written when output, follows pin when input
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        gpio_reg[i] <= 1'b0;
      end else if (ce_i) begin
        if (wr_csr) begin
          gpio_reg[i] <= wdata_i[`TMR_GPIO_BIT];
        end else if (mode_reg[i] == tmr_pkg::TMR_MODE_GPIO && !dir_reg[i]) begin
          gpio_reg[i] <= pin_lvl[i];
        end
      end
    end

    // Status flags: write one to clear, set wins
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        cmp_flag_reg[i] <= 1'b0;
        ovf_flag_reg[i] <= 1'b0;
      end else if (ce_i) begin
        if (hit_w[i]) begin
          cmp_flag_reg[i] <= 1'b1;
        end else if (wr_csr && wdata_i[`TMR_CMP_FLAG_BIT]) begin
          cmp_flag_reg[i] <= 1'b0;
        end
        if (ovf_w[i]) begin
          ovf_flag_reg[i] <= 1'b1;
        end else if (wr_csr && wdata_i[`TMR_OVF_FLAG_BIT]) begin
          ovf_flag_reg[i] <= 1'b0;
        end
      end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        load_reg[i] <= '0;
        cmp_reg[i] <= '0;
      end else if (ce_i) begin
        if (wr_load) begin
          load_reg[i] <= wdata_i[CW-1:0];
        end
        if (wr_cmp) begin
          cmp_reg[i] <= wdata_i[CW-1:0];
        end
      end
    end

    // Measurement capture of the running count
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        capt_reg[i] <= '0;
      end else if (ce_i && te_reg[i]) begin
        if ((mode_reg[i] == tmr_pkg::TMR_MODE_WIDTH && fall)
            || (mode_reg[i] == tmr_pkg::TMR_MODE_PERIOD && rise)
            || (mode_reg[i] == tmr_pkg::TMR_MODE_CAPTURE && rise)) begin
          capt_reg[i] <= count_w[i];
        end
      end
    end

    // Pin waveform
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        out_reg[i] <= 1'b0;
      end else if (ce_i) begin
        if (!te_reg[i]) begin
          out_reg[i] <= 1'b0;
        end else begin
          case (tmr_pkg::tmr_mode_type'(mode_reg[i]))
            tmr_pkg::TMR_MODE_PULSE, tmr_pkg::TMR_MODE_WD_PULSE: out_reg[i] <= hit_w[i];
            tmr_pkg::TMR_MODE_TOGGLE, tmr_pkg::TMR_MODE_WD_TOGGLE: out_reg[i] <= out_reg[i] ^ hit_w[i];
            tmr_pkg::TMR_MODE_PWM: begin
              if (hit_w[i]) begin
                out_reg[i] <= 1'b0;
              end else if (ovf_w[i]) begin
                out_reg[i] <= 1'b1;
              end
            end
            default: out_reg[i] <= 1'b0;
          endcase
        end
      end
    end

    // Pin drivers; tri-state when all timers are idle and the pin is not GPIO
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        drive_reg[i] <= 1'b0;
        oe_reg[i] <= 1'b0;
      end else if (ce_i) begin
        if (mode_reg[i] == tmr_pkg::TMR_MODE_GPIO) begin
          drive_reg[i] <= gpio_reg[i] ^ inv_reg[i];
          oe_reg[i] <= dir_reg[i];
        end else begin
          drive_reg[i] <= out_reg[i] ^ inv_reg[i];
          oe_reg[i] <= is_out && any_te;
        end
      end
    end

    assign irq_set[2*i] = hit_w[i] && compare_irq_enable_reg[i];
    assign irq_set[2*i+1] = ovf_w[i] && overflow_irq_enable_reg[i];
  end

  // ---------------------------------------------------------------------------
  // Interrupt status, enable and clear
  // ---------------------------------------------------------------------------
  assign irq_clr = (wr_i && addr_i == `TMR_IRQ_CLR_ADDR) ? wdata_i[IW-1:0] : '0;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_sts_reg <= '0;
    end else if (ce_i) begin
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_en_reg <= '0;
    end else if (ce_i && wr_i && addr_i == `TMR_IRQ_EN_ADDR) begin
      irq_en_reg <= wdata_i[IW-1:0];
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      irq_reg <= |(((irq_sts_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  always_comb begin
    rdata_next = `TMR_RDATA_ZERO;
    if (addr_i == `TMR_IRQ_STS_ADDR) begin
      rdata_next[IW-1:0] = irq_sts_reg;
    end else if (addr_i == `TMR_IRQ_EN_ADDR) begin
      rdata_next[IW-1:0] = irq_en_reg;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        if (sel_w[k]) begin
          if (sub == `TMR_CSR_OFS) begin
            rdata_next[`TMR_TE_BIT] = te_reg[k];
            rdata_next[`TMR_OVERFLOW_IRQ_ENABLE_BIT] = overflow_irq_enable_reg[k];
            rdata_next[`TMR_COMPARE_IRQ_ENABLE_BIT] = compare_irq_enable_reg[k];
            rdata_next[`TMR_MODE_MSB:`TMR_MODE_LSB] = mode_reg[k];
            rdata_next[`TMR_INV_BIT] = inv_reg[k];
            rdata_next[`TMR_TRM_BIT] = trm_reg[k];
            rdata_next[`TMR_DIR_BIT] = dir_reg[k];
            rdata_next[`TMR_GPIO_BIT] = gpio_reg[k];
            rdata_next[`TMR_OVF_FLAG_BIT] = ovf_flag_reg[k];
            rdata_next[`TMR_CMP_FLAG_BIT] = cmp_flag_reg[k];
          end else if (sub == `TMR_LOAD_OFS) begin
            rdata_next[CW-1:0] = load_reg[k];
          end else if (sub == `TMR_CMP_OFS) begin
            rdata_next[CW-1:0] = cmp_reg[k];
          end else if (sub == `TMR_COUNT_OFS) begin
            if (mode_reg[k] == tmr_pkg::TMR_MODE_WIDTH || mode_reg[k] == tmr_pkg::TMR_MODE_PERIOD
                || mode_reg[k] == tmr_pkg::TMR_MODE_CAPTURE) begin
              rdata_next[CW-1:0] = capt_reg[k];
            end else begin
              rdata_next[CW-1:0] = count_w[k];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= `TMR_RDATA_ZERO;
    end else if (ce_i) begin
      rdata_reg <= rd_i ? rdata_next : `TMR_RDATA_ZERO;
    end
  end

  assign rdata_o = rdata_reg;
  assign pin_out_o = drive_reg;
  assign pin_oe_o = oe_reg;
  assign irq_o = irq_reg;
endmodule : tmr_top
`default_nettype wire

/* File: rtl/tmr_defs.svh */
// Register map, field positions and reset values of the triple timer
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// -----------------------------------------------------------------------------
// Address map
// -----------------------------------------------------------------------------
`define TMR_ADDR_W 8
`define TMR_CSR_OFS 4'h0
`define TMR_LOAD_OFS 4'h4
`define TMR_CMP_OFS 4'h8
`define TMR_COUNT_OFS 4'hC
`define TMR_IRQ_STS_ADDR 8'h30
`define TMR_IRQ_EN_ADDR 8'h34
`define TMR_IRQ_CLR_ADDR 8'h38
`define TMR_CHAN_SPAN 8'h30

// -----------------------------------------------------------------------------
// Control/status fields
// -----------------------------------------------------------------------------
`define TMR_TE_BIT 0
`define TMR_OVERFLOW_IRQ_ENABLE_BIT 1
`define TMR_COMPARE_IRQ_ENABLE_BIT 2
`define TMR_MODE_LSB 4
`define TMR_MODE_MSB 7
`define TMR_INV_BIT 8
`define TMR_TRM_BIT 9
`define TMR_DIR_BIT 10
`define TMR_GPIO_BIT 11
`define TMR_OVF_FLAG_BIT 20
`define TMR_CMP_FLAG_BIT 21

// -----------------------------------------------------------------------------
// Values and counts
// -----------------------------------------------------------------------------
`define TMR_CNT_W 24
`define TMR_CNT_MAX 24'hFFFFFF
`define TMR_CNT_ZERO 24'h000000
`define TMR_DATA_W 32
`define TMR_RDATA_ZERO 32'h00000000
`define TMR_NUM_CHAN 3
`define TMR_PRESCALE 2
`define TMR_IRQ_W 6

`endif

/* File: rtl/tmr_pkg.sv */
// Types shared by the timer modules
`default_nettype none
package tmr_pkg;

  typedef enum logic [3:0] {
    TMR_MODE_GPIO = 4'h0,
    TMR_MODE_PULSE = 4'h1,
    TMR_MODE_TOGGLE = 4'h2,
    TMR_MODE_EVENT = 4'h3,
    TMR_MODE_WIDTH = 4'h4,
    TMR_MODE_PERIOD = 4'h5,
    TMR_MODE_CAPTURE = 4'h6,
    TMR_MODE_PWM = 4'h7,
    TMR_MODE_RSV8 = 4'h8,
    TMR_MODE_WD_PULSE = 4'h9,
    TMR_MODE_WD_TOGGLE = 4'hA,
    TMR_MODE_RSV11 = 4'hB,
    TMR_MODE_RSV12 = 4'hC,
    TMR_MODE_RSV13 = 4'hD,
    TMR_MODE_RSV14 = 4'hE,
    TMR_MODE_RSV15 = 4'hF
  } tmr_mode_type;

  typedef enum logic [2:0] {
    TMR_ST_IDLE = 3'b001,
    TMR_ST_ARMED = 3'b010,
    TMR_ST_RUN = 3'b100
  } tmr_state_type;

endpackage : tmr_pkg
`default_nettype wire

/* File: rtl/tmr_chan_if.sv */
// Link between the register front end and one counter channel
`timescale 1ns/1ps
`default_nettype none
interface tmr_chan_if #(parameter int CW = 24);
  logic en;
  tmr_pkg::tmr_mode_type mode;
  logic trm;
  logic [CW-1:0] load_val;
  logic [CW-1:0] cmp_val;
  logic evt;
  logic load_wr;
  logic [CW-1:0] count;
  logic cmp_hit;
  logic ovf;

  modport ctrl (
    output en, mode, trm, load_val, cmp_val, evt, load_wr,
    input count, cmp_hit, ovf
  );
  modport chan (
    input en, mode, trm, load_val, cmp_val, evt, load_wr,
    output count, cmp_hit, ovf
  );
endinterface : tmr_chan_if
`default_nettype wire

/* File: rtl/tmr_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tmr_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule : tmr_sync
`default_nettype wire

/* File: rtl/tmr_chan.sv */
// One 24-bit up counter with compare and overflow detection
`timescale 1ns/1ps
`include "tmr_defs.svh"
`default_nettype none
module tmr_chan #(
  parameter int CW = `TMR_CNT_W
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  tmr_chan_if.chan bus
);
  tmr_pkg::tmr_state_type state_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic cmp_hit_reg;
  logic ovf_reg;
  logic mode_ok;
  logic cmp_mode;
  logic step;
  logic reload;

  always_comb begin
    case (bus.mode)
      tmr_pkg::TMR_MODE_RSV8, tmr_pkg::TMR_MODE_RSV11, tmr_pkg::TMR_MODE_RSV12,
      tmr_pkg::TMR_MODE_RSV13, tmr_pkg::TMR_MODE_RSV14, tmr_pkg::TMR_MODE_RSV15: mode_ok = 1'b0;
      default: mode_ok = 1'b1;
    endcase
  end

  // Measurement modes never compare
  assign cmp_mode = mode_ok && (bus.mode != tmr_pkg::TMR_MODE_WIDTH) && (bus.mode != tmr_pkg::TMR_MODE_PERIOD)
                    && (bus.mode != tmr_pkg::TMR_MODE_CAPTURE);
  assign step = bus.en && bus.evt && mode_ok && (state_reg != tmr_pkg::TMR_ST_IDLE);
  assign reload = bus.trm && ((bus.mode == tmr_pkg::TMR_MODE_PWM) ? (cnt_reg == CW'(`TMR_CNT_MAX))
                                                                  : (cmp_mode && cnt_reg == bus.cmp_val));

  always_comb begin
    if (state_reg == tmr_pkg::TMR_ST_ARMED) begin
      cnt_next = bus.load_val;
    end else if (reload) begin
      cnt_next = bus.load_val;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= tmr_pkg::TMR_ST_IDLE;
    end else if (ce_i) begin
      if (!bus.en) begin
        state_reg <= tmr_pkg::TMR_ST_IDLE;
      end else begin
        case (state_reg)
          tmr_pkg::TMR_ST_IDLE: state_reg <= tmr_pkg::TMR_ST_ARMED;
          tmr_pkg::TMR_ST_ARMED: if (step) state_reg <= tmr_pkg::TMR_ST_RUN;
          tmr_pkg::TMR_ST_RUN: state_reg <= tmr_pkg::TMR_ST_RUN;
          default: state_reg <= tmr_pkg::TMR_ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Counter and events
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (bus.en && state_reg == tmr_pkg::TMR_ST_IDLE) begin
        cnt_reg <= CW'(`TMR_CNT_ZERO);
      end else if (step) begin
        cnt_reg <= cnt_next;
      end else if (bus.en && bus.load_wr && state_reg == tmr_pkg::TMR_ST_RUN) begin
        cnt_reg <= bus.load_val;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cmp_hit_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else if (ce_i) begin
      cmp_hit_reg <= step && cmp_mode && (cnt_next == bus.cmp_val);
      ovf_reg <= step && (state_reg == tmr_pkg::TMR_ST_RUN) && (cnt_reg == CW'(`TMR_CNT_MAX));
    end
  end

  assign bus.count = cnt_reg;
  assign bus.cmp_hit = cmp_hit_reg;
  assign bus.ovf = ovf_reg;
endmodule : tmr_chan
`default_nettype wire

/* File: dv/tmr_top_asserts.sv */
// Checker for register, interrupt and pin behaviour of the timer
`timescale 1ns/1ps
`include "tmr_defs.svh"
`default_nettype none
module tmr_top_asserts #(
  parameter int NCH = 3,
  parameter int CW = 24,
  parameter int PRESCALE = 2
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [`TMR_ADDR_W-1:0] addr_i,
  input wire logic [`TMR_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [`TMR_DATA_W-1:0] rdata_o,
  input wire logic [NCH-1:0] pin_in_i,
  input wire logic [NCH-1:0] pin_out_o,
  input wire logic [NCH-1:0] pin_oe_o,
  input wire logic irq_o
);
  // ---
  // Shadow of the low control bits
  // ---
  logic [7:0] csr_reg [3];
  logic [7:0] exp_reg;
  logic [5:0] ien_reg;
  wire logic csr_hit = addr_i[3:0] == 4'h0 && addr_i[7:4] < 4'h3;
  wire logic none_on = !(csr_reg[0][0] | csr_reg[1][0] | csr_reg[2][0]);
  wire logic quiet = none_on && csr_reg[0][7:4] != 4'h0 && csr_reg[1][7:4] != 4'h0 && csr_reg[2][7:4] != 4'h0;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      csr_reg <= '{default: 8'h00};
    end else if (ce_i && wr_i && csr_hit) begin
      csr_reg[addr_i[5:4]] <= {wdata_i[7:4], 1'b0, wdata_i[2:0]};
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      exp_reg <= 8'h00;
    end else if (ce_i && rd_i && csr_hit) begin
      exp_reg <= csr_reg[addr_i[5:4]];
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ien_reg <= 6'h00;
    end else if (ce_i && wr_i && addr_i == 8'h34) begin
      ien_reg <= wdata_i[5:0];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  AST_RDATA_IDLE: assert property (ce_i && !rd_i |=> rdata_o == 32'h00000000)
    else $error("Read data not zero outside a read");
  AST_CSR_READBACK: assert property (ce_i && rd_i && csr_hit |=> rdata_o[7:0] == exp_reg)
    else $error("Control bits read back wrong");
  AST_UNMAPPED_ZERO: assert property (ce_i && rd_i && addr_i >= 8'h3C |=> rdata_o == 32'h00000000)
    else $error("Unmapped read not zero");
  AST_RESET_QUIET: assert property ($fell(reset_i) |-> !irq_o && pin_oe_o == '0)
    else $error("Outputs active after reset");
  AST_IRQ_MASKED: assert property (ce_i && wr_i && addr_i == 8'h34 && wdata_i[5:0] == 6'h00 |=> ##1 !irq_o)
    else $error("Interrupt high with all enables off");
  AST_OE_TRISTATE: assert property (quiet [*3] |-> pin_oe_o == '0)
    else $error("Pin driven while all timers off");
  AST_IRQ_NEEDS_EN: assert property ($rose(irq_o) |-> ien_reg != 6'h00)
    else $error("Interrupt rose with no enable");
  AST_IRQ_CLEAR: assert property (ce_i && wr_i && addr_i == 8'h38 && wdata_i[5:0] == 6'h3F && none_on
    |=> ##1 !irq_o)
    else $error("Interrupt stayed after clear");
  CV_IRQ: cover property ($rose(irq_o));
  CV_OE: cover property (pin_oe_o != '0);
  CV_CSR_RD: cover property (rd_i && csr_hit);
endmodule : tmr_top_asserts
bind tmr_top tmr_top_asserts #(.NCH(NCH), .CW(CW), .PRESCALE(PRESCALE)) i_tmr_top_asserts (
  .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
  .irq_o(irq_o));
`default_nettype wire

/* File: dv/test_tmr_top.sv */
// Self-checking bench for the timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end
module test_tmr_top;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] pin_in_i = 3'h0;
  logic [31:0] rdata_o;
  logic [2:0] pin_out_o;
  logic [2:0] pin_oe_o;
  logic irq_o;
  logic [31:0] d;
  logic [31:0] c;
  int fail_count = 0;
  int compares = 0;
  always #5 mclk_i = ~mclk_i;
  tmr_top i_tmr_top (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .irq_o(irq_o));
  // ---
  // Bus tasks
  // ---
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
    // Look at outputs once the edge's updates have settled
    #1;
  endtask : idle
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(8'(16 * i));
      `CHK(d[7:0], 8'h00)
    end
    wr(8'h00, 32'h0000000E);
    rd(8'h00);
    `CHK(d[3:0], 4'h6)
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40);
    `CHK(d, 32'h00000000)
    $display("test reset done");
    wr(8'h14, 32'h00000100);
    for (int m = 0; m < 16; m++) begin
      wr(8'h10, 32'(m) << 4);
      rd(8'h10);
      `CHK(d[7:4], 4'(m))
      if (m == 8 || m > 10) begin
        wr(8'h10, (32'(m) << 4) | 32'h1);
        idle(12);
        rd(8'h1C);
        `CHK(d[23:0], 24'h000000)
        wr(8'h10, 32'h00000000);
      end
    end
    wr(8'h10, 32'h00000C00);
    idle(3);
    `CHK(pin_oe_o[1], 1'b1)
    `CHK(pin_out_o[1], 1'b1)
    wr(8'h10, 32'h00000430);
    idle(3);
    `CHK(pin_oe_o[1], 1'b0)
    $display("test modes done");
    wr(8'h34, 32'h0000003F);
    wr(8'h04, 32'h00000005);
    wr(8'h08, 32'h00000009);
    wr(8'h00, 32'h00000015);
    rd(8'h0C);
    `CHK(d[23:0], 24'h000000)
    for (int k = 0; k < 40 && d[23:0] != 24'h000009; k++) begin
      rd(8'h0C);
      `CHK(d[23:0] == 24'h0 || (d[23:0] >= 24'h5 && d[23:0] <= 24'h9), 1'b1)
    end
    `CHK(d[23:0], 24'h000009)
    rd(8'h30);
    `CHK(d[0], 1'b1)
    rd(8'h00);
    `CHK(d[21], 1'b1)
    `CHK(irq_o, 1'b1)
    wr(8'h00, 32'h00200014);
    rd(8'h0C);
    c = d;
    idle(10);
    rd(8'h0C);
    `CHK(d, c)
    wr(8'h38, 32'h0000003F);
    rd(8'h30);
    `CHK(d[5:0], 6'h00)
    wr(8'h00, 32'h00000011);
    idle(30);
    rd(8'h30);
    `CHK(d[0], 1'b0)
    rd(8'h00);
    `CHK(d[21], 1'b1)
    wr(8'h00, 32'h00000010);
    wr(8'h00, 32'h00000011);
    rd(8'h0C);
    `CHK(d[23:0], 24'h000000)
    wr(8'h00, 32'h00000010);
    $display("test compare done");
    wr(8'h38, 32'h0000003F);
    wr(8'h24, 32'h00FFFFFD);
    wr(8'h28, 32'h00000100);
    wr(8'h20, 32'h00000013);
    idle(20);
    rd(8'h30);
    `CHK(d[5], 1'b1)
    rd(8'h20);
    `CHK(d[20], 1'b1)
    rd(8'h2C);
    `CHK(d[23:0] < 24'h000010, 1'b1)
    `CHK(irq_o, 1'b1)
    wr(8'h34, 32'h00000000);
    idle(1);
    `CHK(irq_o, 1'b0)
    wr(8'h34, 32'h0000003F);
    wr(8'h20, 32'h00100010);
    wr(8'h38, 32'h0000003F);
    wr(8'h20, 32'h00000011);
    idle(20);
    rd(8'h30);
    `CHK(d[5], 1'b0)
    wr(8'h20, 32'h000000A1);
    idle(3);
    `CHK(pin_oe_o[2], 1'b1)
    $display("test overflow done");
    wr(8'h00, 32'h00000010);
    wr(8'h10, 32'h00000030);
    wr(8'h10, 32'h00000031);
    repeat (3) begin
      @(posedge mclk_i);
      pin_in_i[1] <= 1'b1;
      idle(4);
      @(posedge mclk_i);
      pin_in_i[1] <= 1'b0;
      idle(4);
    end
    rd(8'h1C);
    `CHK(d[23:0], 24'h000102)
    wr(8'h10, 32'h00000030);
    wr(8'h20, 32'h000000A0);
    idle(3);
    `CHK(pin_oe_o, 3'b000)
    wr(8'h38, 32'h0000003F);
    idle(2);
    `CHK(irq_o, 1'b0)
    $display("test pins done");
    report_and_stop();
  end
endmodule : test_tmr_top
`default_nettype wire
